// ===== extosc_ctrl.sv
// Purpose: External oscillator mode, bias and valid-flag register
// Assumes: Oscillator status and clock pins are asynchronous to mclk
// Notes: Contract list follows
// Contract
// (R1) Bit 7 reads 1 only when the external oscillator runs and has settled.
// (R2) Valid flag always reads 0 in both CMOS clock modes.
// (R3) Mode bits 6:4: 00x disabled, 100 RC, 101 capacitor oscillator.
// (R4) Mode 010 passes CMOS clock through; 011 halves it first.
// (R5) Mode 110 runs crystal natively; 111 runs crystal then halves it.
// (R6) Bit 3 reserved: reads 0; software writes 0.
// (R7) Bits 2:0 select one of eight bias current levels, read/write.
// (R8) Writes to read-only bit 7 ignored; reset clears register, oscillator off.
`timescale 1ns/1ps
`default_nettype none
module extosc_ctrl
  import extosc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic osc_running_pin,
  input wire logic ext_clk_pin,
  output logic [2:0] ext_osc_mode_field,
  output logic [2:0] ext_osc_bias_select,
  output logic ext_osc_valid_flag,
  output logic osc_enable,
  output logic rc_select,
  output logic cap_select,
  output logic xtal_select,
  output logic cmos_select,
  output logic ext_clk_tick
);
  // ----------------------------------------
  // Register write and read
  // ----------------------------------------
  logic hit_wr;
  logic hit_rd;
  assign hit_wr = sfr_wr && (sfr_addr == EXTOSC_CTRL_ADDR);
  assign hit_rd = sfr_rd && (sfr_addr == EXTOSC_CTRL_ADDR);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_osc_mode_field <= EXTOSC_CTRL_RESET[MODE_MSB:MODE_LSB]; // [R8]
      ext_osc_bias_select <= EXTOSC_CTRL_RESET[BIAS_MSB:BIAS_LSB]; // [R8]
    end
    else if (hit_wr)
    begin
      ext_osc_mode_field <= sfr_wdata[MODE_MSB:MODE_LSB]; // [R3]
      ext_osc_bias_select <= sfr_wdata[BIAS_MSB:BIAS_LSB]; // [R7]
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (hit_rd)
      sfr_rdata <= {ext_osc_valid_flag, ext_osc_mode_field, 1'b0, ext_osc_bias_select}; // [R6]
    else
      sfr_rdata <= 8'h00;
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic div2_mode;
  always_comb
  begin
    osc_enable = 1'b1;
    rc_select = 1'b0;
    cap_select = 1'b0;
    xtal_select = 1'b0;
    cmos_select = 1'b0;
    div2_mode = 1'b0;
    unique case (ext_osc_mode_field)
      MODE_OFF0, MODE_OFF1: osc_enable = 1'b0; // [R3]
      MODE_CMOS: cmos_select = 1'b1; // [R4]
      MODE_CMOS_DIV2:
      begin
        cmos_select = 1'b1; // [R4]
        div2_mode = 1'b1;
      end
      MODE_RC: rc_select = 1'b1; // [R3]
      MODE_CAP: cap_select = 1'b1; // [R3]
      MODE_XTAL: xtal_select = 1'b1; // [R5]
      MODE_XTAL_DIV2:
      begin
        xtal_select = 1'b1; // [R5]
        div2_mode = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] run_sync;
  logic [2:0] clk_sync;
  logic run_level;
  logic clk_level;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      run_sync <= 3'h0;
      clk_sync <= 3'h0;
    end
    else
    begin
      run_sync <= {run_sync[1:0], osc_running_pin};
      clk_sync <= {clk_sync[1:0], ext_clk_pin};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      run_level <= 1'b0;
      clk_level <= 1'b0;
    end
    else
    begin
      if (run_sync[1] == run_sync[2])
        run_level <= run_sync[2];
      if (clk_sync[1] == clk_sync[2])
        clk_level <= clk_sync[2];
    end
  end

  // ----------------------------------------
  // Settle counter and valid flag
  // ----------------------------------------
  logic osc_self;
  logic [15:0] settle_cnt;
  assign osc_self = rc_select || cap_select || xtal_select;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      settle_cnt <= 16'h0000;
    else if (!osc_self || !run_level || hit_wr)
      settle_cnt <= 16'h0000; // [R1]
    else if (settle_cnt != 16'(SETTLE))
      settle_cnt <= settle_cnt + 16'h0001; // [R1]
  end

  // Valid only for modes that run the on-chip oscillator circuit
  assign ext_osc_valid_flag = osc_self && run_level && (settle_cnt == 16'(SETTLE)); // [R1] [R2]

  // ----------------------------------------
  // Clock edge enable, with optional halving
  // ----------------------------------------
  logic clk_prev;
  logic half_phase;
  logic clk_edge;
  assign clk_edge = clk_level && !clk_prev;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clk_prev <= 1'b0;
    else
      clk_prev <= clk_level;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      half_phase <= 1'b0;
    else if (!div2_mode)
      half_phase <= 1'b0;
    else if (clk_edge)
      half_phase <= !half_phase; // [R4] [R5]
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ext_clk_tick <= 1'b0;
    else
      ext_clk_tick <= osc_enable && clk_edge && (!div2_mode || half_phase); // [R4] [R5]
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_cmos_valid_low: assert property (@(posedge mclk) disable iff (rst) // [R2]
    cmos_select |-> !ext_osc_valid_flag)
    else $error("valid flag set in CMOS mode");

  a_off_valid_low: assert property (@(posedge mclk) disable iff (rst) // [R3]
    (ext_osc_mode_field[2:1] == 2'b00) |-> (!ext_osc_valid_flag && !osc_enable))
    else $error("disabled mode shows activity");

  a_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (rst) // [R6]
    sfr_rdata[RSVD_BIT] == 1'b0)
    else $error("reserved bit read as one");

  a_read_shows_state: assert property (@(posedge mclk) disable iff (rst) // [R1]
    hit_rd |=> sfr_rdata == {$past(ext_osc_valid_flag), $past(ext_osc_mode_field), 1'b0,
      $past(ext_osc_bias_select)})
    else $error("read data does not match register");

  a_write_takes: assert property (@(posedge mclk) disable iff (rst) // [R7]
    hit_wr |=> (ext_osc_bias_select == $past(sfr_wdata[BIAS_MSB:BIAS_LSB])) &&
      (ext_osc_mode_field == $past(sfr_wdata[MODE_MSB:MODE_LSB])))
    else $error("write not stored");

  a_valid_after_settle: assert property (@(posedge mclk) disable iff (rst) // [R1]
    $rose(ext_osc_valid_flag) |-> $past(run_level) && run_level && !$past(hit_wr))
    else $error("valid rose without settling");

  a_cmos_pass_edge: assert property (@(posedge mclk) disable iff (rst) // [R4]
    (ext_osc_mode_field == MODE_CMOS) && clk_edge |=> ext_clk_tick)
    else $error("CMOS edge not passed");

  a_xtal_half_rate: assert property (@(posedge mclk) disable iff (rst) // [R5]
    (ext_osc_mode_field == MODE_XTAL_DIV2) && clk_edge |=> ext_clk_tick == $past(half_phase))
    else $error("crystal divide by two wrong");

  a_reset_clears: assert property (@(posedge mclk) // [R8]
    rst |=> (ext_osc_mode_field == 3'h0) && (ext_osc_bias_select == 3'h0) || !$past(rst))
    else $error("reset did not clear register");

  c_valid_rises: cover property (@(posedge mclk) disable iff (rst) $rose(ext_osc_valid_flag));
  c_div2_tick: cover property (@(posedge mclk) disable iff (rst) div2_mode && ext_clk_tick);
  c_reg_read: cover property (@(posedge mclk) disable iff (rst) hit_wr ##1 hit_rd);
endmodule
`default_nettype wire

// ===== extosc_pkg.sv
// Purpose: Constants for the external oscillator control register
// Assumes: 8-bit special-function-register space
// Notes: Settle time is a plain default, not a device figure
package extosc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] EXTOSC_CTRL_ADDR = 8'hb1;
  localparam logic [7:0] EXTOSC_CTRL_RESET = 8'h00;
  localparam int VALID_BIT = 7;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 6;
  localparam int RSVD_BIT = 3;
  localparam int BIAS_LSB = 0;
  localparam int BIAS_MSB = 2;
  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [2:0] MODE_OFF0 = 3'h0;
  localparam logic [2:0] MODE_OFF1 = 3'h1;
  localparam logic [2:0] MODE_CMOS = 3'h2;
  localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] MODE_RC = 3'h4;
  localparam logic [2:0] MODE_CAP = 3'h5;
  localparam logic [2:0] MODE_XTAL = 3'h6;
  localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES_CALC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CYCLES = (SETTLE_CYCLES_CALC < 1) ? 1 : SETTLE_CYCLES_CALC;
endpackage

// ===== extosc_src_model.sv
// Purpose: Model of the external oscillator source behind the pins
// Assumes: Clock stands low while the source is stopped
// Notes: HALF sets the half period in mclk cycles
`timescale 1ns/1ps
`default_nettype none
module extosc_src_model #(
  parameter int HALF = 4
)
(
  input wire logic mclk,
  input wire logic run,
  output logic osc_running_pin,
  output logic ext_clk_pin
);
  int cnt = 0;
  initial
  begin
    osc_running_pin = 1'b0;
    ext_clk_pin = 1'b0;
  end
  // Running level follows run; clock toggles only while running
  always @(posedge mclk)
  begin
    osc_running_pin <= run;
    if (!run)
    begin
      cnt <= 0;
      ext_clk_pin <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      ext_clk_pin <= ~ext_clk_pin;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the external oscillator register
// Assumes: SETTLE shortened to 4 cycles
// Notes: Source clock period is 8 mclk cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import extosc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] mode, bias;
  logic valid, en, rc, cap, xt, cm, tick, run_pin, clk_pin;
  int fail_count = 0, num_checks = 0, tick_cnt = 0, n;
  logic [2:0] tm [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  extosc_src_model #(.HALF(4)) src (.mclk(mclk), .run(run), .osc_running_pin(run_pin),
    .ext_clk_pin(clk_pin));
  extosc_ctrl #(.SETTLE(4)) dut (.mclk(mclk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .osc_running_pin(run_pin),
    .ext_clk_pin(clk_pin), .ext_osc_mode_field(mode), .ext_osc_bias_select(bias),
    .ext_osc_valid_flag(valid), .osc_enable(en), .rc_select(rc), .cap_select(cap),
    .xtal_select(xt), .cmos_select(cm), .ext_clk_tick(tick));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (tick === 1'b1)
      tick_cnt++;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    #1;
    addr = a;
    wr = w;
    rd = ~w;
    wdata = d;
    @(posedge mclk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
    chk("reset image", rdata, 8'h00);
    chk("reset enable", {7'h0, en}, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_modes();
    for (int m = 0; m < 8; m++)
    begin
      acc(EXTOSC_CTRL_ADDR, 1'b1, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
      chk("mode", {5'h0, mode}, 8'(m));
      chk("bias", {5'h0, bias}, 8'(7 - m));
      chk("decode", {3'h0, en, rc, cap, xt, cm}, {3'h0, m > 1, m == 4, m == 5, m > 5,
        m == 2 || m == 3});
      acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
      chk("readback", rdata, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
    end
    acc(EXTOSC_CTRL_ADDR, 1'b1, 8'hf7);
    acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
    chk("ro bits", rdata, 8'h77);
    acc(8'hb2, 1'b1, 8'h00);
    acc(8'hb2, 1'b0, 8'h00);
    chk("unmapped", rdata, 8'h00);
    chk("unmapped wr", {5'h0, mode}, 8'h07);
    $display("test_modes done");
  endtask
  task automatic test_reset_again();
    acc(EXTOSC_CTRL_ADDR, 1'b1, 8'h57);
    chk("pre reset fields", {1'h0, en, mode, bias}, 8'h6f);
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("mid reset fields", {1'h0, en, mode, bias}, 8'h00);
    acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
    chk("mid reset image", rdata, 8'h00);
    $display("test_reset_again done");
  endtask
  task automatic test_valid();
    run = 1'b1;
    acc(EXTOSC_CTRL_ADDR, 1'b1, 8'h45);
    n = 0;
    while (valid !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
    chk("valid rc", rdata, 8'hc5);
    run = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    chk("valid drop", {7'h0, valid}, 8'h00);
    run = 1'b1;
    acc(EXTOSC_CTRL_ADDR, 1'b1, 8'h20);
    repeat (40) @(posedge mclk);
    acc(EXTOSC_CTRL_ADDR, 1'b0, 8'h00);
    chk("valid cmos", rdata, 8'h20);
    $display("test_valid done");
  endtask
  task automatic test_ticks();
    for (int i = 0; i < 5; i++)
    begin
      acc(EXTOSC_CTRL_ADDR, 1'b1, {1'b0, tm[i], 4'h0});
      repeat (24) @(posedge mclk);
      #1;
      tick_cnt = 0;
      repeat (80) @(posedge mclk);
      #1;
      chk("ticks", 8'(tick_cnt), tm[i][1] ? (tm[i][0] ? 8'h05 : 8'h0a) : 8'h00);
    end
    $display("test_ticks done");
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    test_reset();
    test_modes();
    test_reset_again();
    test_valid();
    test_ticks();
    test_done();
  end
  initial
  begin
    #50us;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
